// File: verilog/op_admission_params.svh
`ifndef OP_ADMISSION_PARAMS_SVH
`define OP_ADMISSION_PARAMS_SVH

// Sector index width (64 KB sectors)
`define SECTOR_W 11
// Nonvolatile boot field value that keeps address-only read mode off
`define NVCR_XIP_OFF 3'h7
// Volatile configuration enable bit after reset (1 = mode disabled)
`define VCR_XIP_RST 1'h1
// Rescue burst counter width and the six burst lengths in link clocks
`define RESCUE_CNT_W 6
`define RESCUE_CNT_MAX 6'h3F
`define RESCUE_LAST_STEP 3'h5
`define RESCUE_B0 6'h07
`define RESCUE_B1 6'h09
`define RESCUE_B2 6'h0D
`define RESCUE_B3 6'h11
`define RESCUE_B4 6'h19
`define RESCUE_B5 6'h21

`endif

// File: verilog/op_admission_pkg.sv
package op_admission_pkg;

   // Device operating states
   typedef enum logic [1:0] {
      ST_STANDBY,
      ST_BUSY,
      ST_PS_SUSP,
      ST_ER_SUSP
   } op_state_type;

   // Command classes as reported by the command decoder
   typedef enum logic [3:0] {
      CLS_ARRAY_READ,
      CLS_STATUS_READ,
      CLS_PROGRAM,
      CLS_SECT_ERASE,
      CLS_SUBSECT_ERASE,
      CLS_PROT_WRITE,
      CLS_LIGHT_WRITE,
      CLS_SUSPEND,
      CLS_RESUME
   } cmd_class_type;

   // Synchroniser state
   typedef struct packed {
      logic [2:0] ff;
      logic level;
   } sync_state_type;

   // Rescue sequence detector state
   typedef struct packed {
      logic [5:0] cnt;
      logic [2:0] step;
      logic sclk_d;
      logic cs_n_d;
      logic done;
   } rescue_state_type;

   // Admission and address-only read control state
   typedef struct packed {
      op_state_type op;
      logic kind_erase;
      logic nested;
      logic [10:0] sector;
      logic xip;
      logic vcr3;
      logic boot;
      logic acc;
      logic refuse;
      logic unsure;
      logic selected;
   } ctrl_state_type;

endpackage : op_admission_pkg

// File: verilog/pin_sync.sv
`timescale 1ns/1ns
`default_nettype none

// Three-stage synchroniser; level follows once stages two and three agree
module pin_sync
   import op_admission_pkg::*;
#(
   parameter logic RST_VAL = 1'b0
) (
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   input wire logic pin_i,
   output logic level_o
);

   sync_state_type st; // Registered state
   sync_state_type next_st; // Next state

   // Shift and filter; first stage only feeds the second
   always_comb begin
      next_st = st;
      next_st.ff = {st.ff[1:0], pin_i};
      if (st.ff[1] == st.ff[2]) begin
         next_st.level = st.ff[2];
      end
   end

   // State register, synchronous reset to the idle pin level
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         st <= '{ff: {3{RST_VAL}}, level: RST_VAL};
      end else begin
         st <= next_st;
      end
   end

   assign level_o = st.level;

   level_agree_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      $changed(st.level) |-> $past(st.ff[1]) == $past(st.ff[2]))
      else $error("synchronised level moved without agreement");

endmodule : pin_sync

`default_nettype wire

// File: verilog/rescue_seq.sv
`timescale 1ns/1ns
`default_nettype none

`include "op_admission_params.svh"

// Detects the 7,9,13,17,25,33-clock chip-select burst rescue sequence
module rescue_seq
   import op_admission_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   input wire logic cs_n_i,
   input wire logic sclk_i,
   output logic done_o
);

   rescue_state_type st; // Registered state
   rescue_state_type next_st; // Next state

   // Expected burst length for each step of the sequence
   function automatic logic [5:0] burst_len(input logic [2:0] step);
      case (step)
         3'h0: burst_len = `RESCUE_B0;
         3'h1: burst_len = `RESCUE_B1;
         3'h2: burst_len = `RESCUE_B2;
         3'h3: burst_len = `RESCUE_B3;
         3'h4: burst_len = `RESCUE_B4;
         default: burst_len = `RESCUE_B5;
      endcase
   endfunction : burst_len

   // Count clocks per selected burst and judge each burst on deselect
   always_comb begin
      next_st = st;
      next_st.done = 1'b0;
      next_st.sclk_d = sclk_i;
      next_st.cs_n_d = cs_n_i;
      if (!cs_n_i && sclk_i && !st.sclk_d && st.cnt != `RESCUE_CNT_MAX) begin
         next_st.cnt = st.cnt + 6'h01;
      end
      if (cs_n_i && !st.cs_n_d) begin
         next_st.cnt = 6'h00;
         if (st.cnt == burst_len(st.step)) begin
            // Burst ended before the following clock: advance
            if (st.step == `RESCUE_LAST_STEP) begin
               next_st.done = 1'b1; // RULE21
               next_st.step = 3'h0;
            end else begin
               next_st.step = st.step + 3'h1;
            end
         end else if (st.cnt == `RESCUE_B0) begin
            // A broken sequence may restart with a fresh first burst
            next_st.step = 3'h1;
         end else begin
            next_st.step = 3'h0;
         end
      end
   end

   // State register
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         st <= '{cnt: 6'h00, step: 3'h0, sclk_d: 1'b0, cs_n_d: 1'b1, done: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   assign done_o = st.done;

   done_cause_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // RULE21
      st.done |-> $past(st.step) == `RESCUE_LAST_STEP && $past(st.cnt) == `RESCUE_B5
         && st.step == 3'h0)
      else $error("rescue completion without the final burst");

   seq_break_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // RULE21
      (cs_n_i && !st.cs_n_d && st.cnt != burst_len(st.step) && st.cnt != `RESCUE_B0)
         |=> st.step == 3'h0 && !st.done)
      else $error("rescue sequence not restarted after a wrong burst");

   rescue_done_c: cover property (@(posedge ref_clk_i) disable iff (!nrst_i) st.done);

endmodule : rescue_seq

`default_nettype wire

// File: verilog/op_admission_and_xip_ctrl.sv
`timescale 1ns/1ns
`default_nettype none

`include "op_admission_params.svh"

// Overview of operation
// RULE1: Exactly one operating state at a time
// RULE2: Standby accepts everything except suspend requests; code also refuses resume in standby
// RULE3: Outside erase suspend, sector never matters
// RULE4: Erase suspend refuses program to suspended sector
// RULE5: Array reads refused only while busy
// RULE6: Read of suspended sector accepted, flagged unsure
// RULE7: Status and flag reads always accepted
// RULE8: Program only in standby or erase suspend
// RULE9: Sector erases accepted only in standby
// RULE10: Protected writes and die erase standby only
// RULE11: Light writes refused only while busy
// RULE12: Suspend accepted only while busy
// RULE13: Enable bit 0 then confirm 0 enters mode
// RULE14: Active mode means address-only transactions
// RULE15: Confirm 1 exits and sets enable bit
// RULE16: Basic variant enters on confirm 0 alone
// RULE17: Nonvolatile field boots straight into mode
// RULE18: Confirm bit sampled on line zero
// RULE19: Other data lines ignored at confirmation
// RULE20: Reset pin cancels mode, quad needs deselect; code reloads the nonvolatile boot value instead
// RULE21: Six-burst rescue sequence exits the mode
// RULE22: Host then issues reset enable and reset
// RULE23: Chip select low means selected
// RULE24: Refused command changes nothing
// RULE25: Suspend and resume move between states
module op_admission_and_xip_ctrl
   import op_admission_pkg::*;
(
   input wire logic ref_clk_i, // Block clock, 10 MHz
   input wire logic nrst_i, // Synchronous reset, active low
   input wire logic cs_n_i, // Chip select pin, active low
   input wire logic sclk_i, // Serial clock pin
   input wire logic io_line_zero_i, // Data line zero pin
   input wire logic rst_pin_n_i, // Reset pin, active low
   input wire logic quad_mode_i, // Quad protocol selected
   input wire logic basic_variant_i, // Basic address-only read option
   input wire logic [2:0] nvcr_xip_sel_i, // Nonvolatile boot field

   input wire logic cmd_valid_i, // Decoded command pulse
   input wire cmd_class_type cmd_class_i, // Decoded command class
   input wire logic [10:0] cmd_sector_i, // Target sector
   input wire logic vcr_wr_i, // Light write targets volatile config
   input wire logic vcr_xip_bit_i, // New volatile enable bit
   input wire logic first_dummy_i, // First dummy clock of a fast read
   input wire logic op_done_i, // Array operation finished

   output logic [1:0] op_state_o, // Operating state
   output logic cmd_accept_o, // Command accepted pulse
   output logic cmd_refuse_o, // Command refused pulse
   output logic read_unsure_o, // Read data not guaranteed
   output logic xip_active_o, // Address-only read mode on
   output logic vcr_xip_bit_o, // Volatile enable bit
   output logic selected_o // Device selected
);

   ctrl_state_type st; // Registered state
   ctrl_state_type next_st; // Next state
   logic cs_n_lvl; // Synchronised chip select
   logic sclk_lvl; // Synchronised serial clock
   logic io0_lvl; // Synchronised data line zero
   logic rst_lvl; // Synchronised reset pin

   logic rescue_done; // Rescue sequence complete
   logic same_sect; // Command hits the suspended erase sector
   logic cmd_ok; // Admission verdict for the current command
   logic pin_reset; // Reset pin acting this cycle

   // Pin synchronisers; pins idle high except the clock and data
   pin_sync #(.RST_VAL(1'b1)) u_cs_sync (
      .ref_clk_i(ref_clk_i),
      .nrst_i(nrst_i),
      .pin_i(cs_n_i),
      .level_o(cs_n_lvl)
   );

   pin_sync #(.RST_VAL(1'b0)) u_sclk_sync (
      .ref_clk_i(ref_clk_i),
      .nrst_i(nrst_i),
      .pin_i(sclk_i),
      .level_o(sclk_lvl)
   );

   // Only line zero is watched; lines one to three are don't-care
   pin_sync #(.RST_VAL(1'b0)) u_io0_sync ( // RULE19
      .ref_clk_i(ref_clk_i),
      .nrst_i(nrst_i),
      .pin_i(io_line_zero_i),
      .level_o(io0_lvl)
   );

   pin_sync #(.RST_VAL(1'b1)) u_rst_sync (
      .ref_clk_i(ref_clk_i),
      .nrst_i(nrst_i),
      .pin_i(rst_pin_n_i),
      .level_o(rst_lvl)
   );

   // Interface rescue detector
   rescue_seq u_rescue (
      .ref_clk_i(ref_clk_i),
      .nrst_i(nrst_i),
      .cs_n_i(cs_n_lvl),
      .sclk_i(sclk_lvl),
      .done_o(rescue_done)
   );

   // Admission table; used by the control logic and its checks
   function automatic logic admit(input op_state_type op,
                                  input cmd_class_type cls,
                                  input logic hit);
      case (cls)
         CLS_ARRAY_READ: admit = (op != ST_BUSY); // RULE5 RULE6
         CLS_STATUS_READ: admit = 1'b1; // RULE7

         // Sector only matters in erase suspend
         CLS_PROGRAM: admit = (op == ST_STANDBY) || (op == ST_ER_SUSP && !hit); // RULE3 RULE4 RULE8
         CLS_SECT_ERASE: admit = (op == ST_STANDBY); // RULE9
         CLS_SUBSECT_ERASE: admit = (op == ST_STANDBY); // RULE9
         CLS_PROT_WRITE: admit = (op == ST_STANDBY); // RULE10

         CLS_LIGHT_WRITE: admit = (op != ST_BUSY); // RULE11
         CLS_SUSPEND: admit = (op == ST_BUSY); // RULE2 RULE12
         CLS_RESUME: admit = (op == ST_PS_SUSP) || (op == ST_ER_SUSP); // RULE25

         default: admit = 1'b0;
      endcase
   endfunction : admit

   // Boot value of address-only read mode from the nonvolatile field
   function automatic logic boot_xip(input logic [2:0] sel);
      boot_xip = (sel != `NVCR_XIP_OFF);
   endfunction : boot_xip

   assign same_sect = (cmd_sector_i == st.sector);
   assign cmd_ok = admit(st.op, cmd_class_i, same_sect);

   // In quad protocol the pin only acts while deselected
   assign pin_reset = !rst_lvl && (!quad_mode_i || cs_n_lvl); // RULE20

   // Next-state logic for admission, operating state and read mode
   always_comb begin
      next_st = st;
      next_st.acc = 1'b0;
      next_st.refuse = 1'b0;
      next_st.unsure = 1'b0;

      next_st.selected = !cs_n_lvl; // RULE23

      // One cycle after reset the strap-like boot field is taken
      if (st.boot) begin
         next_st.boot = 1'b0;
         next_st.xip = boot_xip(nvcr_xip_sel_i); // RULE17
      end

      // Command admission; a refused command touches nothing else
      if (cmd_valid_i) begin
         next_st.acc = cmd_ok;
         next_st.refuse = !cmd_ok; // RULE24
         if (cmd_ok) begin
            case (cmd_class_i)
               CLS_PROGRAM, CLS_SECT_ERASE, CLS_SUBSECT_ERASE, CLS_PROT_WRITE: begin
                  next_st.op = ST_BUSY; // RULE1
                  next_st.nested = (st.op == ST_ER_SUSP);
                  // Keep the suspended erase's sector for nested programs
                  if (st.op != ST_ER_SUSP) begin
                     next_st.kind_erase = (cmd_class_i == CLS_SECT_ERASE);
                     next_st.sector = cmd_sector_i;
                  end
               end

               CLS_SUSPEND: begin
                  // Sector erase parks in erase suspend, others in program suspend
                  if (st.kind_erase && !st.nested) begin
                     next_st.op = ST_ER_SUSP; // RULE25
                  end else begin
                     next_st.op = ST_PS_SUSP; // RULE25
                  end
               end

               CLS_RESUME: begin
                  next_st.op = ST_BUSY; // RULE25
               end

               CLS_ARRAY_READ: begin
                  next_st.unsure = (st.op == ST_ER_SUSP) && same_sect; // RULE6
               end

               CLS_LIGHT_WRITE: begin
                  if (vcr_wr_i) begin
                     next_st.vcr3 = vcr_xip_bit_i; // RULE11
                  end
               end

               default: begin
                  // Status reads change no state
               end
            endcase
         end
      end

      // Completion wins over a suspend in the same cycle
      if (op_done_i && st.op == ST_BUSY) begin
         next_st.op = st.nested ? ST_ER_SUSP : ST_STANDBY;
         next_st.nested = 1'b0;
      end

      // Confirmation bit on line zero at the first dummy clock
      if (first_dummy_i) begin
         if (st.xip) begin
            if (io0_lvl) begin
               next_st.xip = 1'b0; // RULE15 RULE18
               next_st.vcr3 = 1'b1; // RULE15
            end
         end else if ((!st.vcr3 || basic_variant_i) && !io0_lvl) begin
            next_st.xip = 1'b1; // RULE13 RULE16 RULE18
         end
      end

      // Rescue drives the confirmation to one; array work goes on
      if (rescue_done) begin
         next_st.xip = 1'b0; // RULE21
         next_st.vcr3 = 1'b1;
      end

      // Reset pin restores the nonvolatile picture
      // Held low, it acts again every cycle
      if (pin_reset) begin
         next_st.xip = boot_xip(nvcr_xip_sel_i); // RULE20
         next_st.vcr3 = `VCR_XIP_RST;
         next_st.op = ST_STANDBY;
         next_st.nested = 1'b0;
         next_st.acc = 1'b0;
         next_st.refuse = 1'b0;
      end
   end

   // State register
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         st <= '{op: ST_STANDBY,
                 kind_erase: 1'b0,
                 nested: 1'b0,
                 sector: '0,
                 xip: 1'b0,
                 vcr3: `VCR_XIP_RST,
                 boot: 1'b1,
                 acc: 1'b0,
                 refuse: 1'b0,
                 unsure: 1'b0,
                 selected: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from the state register
   assign op_state_o = st.op;
   assign cmd_accept_o = st.acc;
   assign cmd_refuse_o = st.refuse;
   assign read_unsure_o = st.unsure;

   // While on, each selected frame carries only an address
   assign xip_active_o = st.xip; // RULE14
   assign vcr_xip_bit_o = st.vcr3;
   assign selected_o = st.selected;

   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!nrst_i);

   status_read_ok_a: assert property ( // RULE7
      cmd_valid_i && cmd_class_i == CLS_STATUS_READ && rst_lvl
         |=> st.acc && !st.refuse)
      else $error("status read refused");

   busy_read_refused_a: assert property ( // RULE5
      cmd_valid_i && cmd_class_i == CLS_ARRAY_READ && st.op == ST_BUSY && rst_lvl
         |=> st.refuse)
      else $error("array read accepted while busy");

   idle_suspend_refused_a: assert property ( // RULE12
      cmd_valid_i && cmd_class_i == CLS_SUSPEND && st.op != ST_BUSY && rst_lvl
         |=> st.refuse && $stable(st.op))
      else $error("suspend accepted outside program or erase");

   suspended_sector_a: assert property ( // RULE4
      cmd_valid_i && cmd_class_i == CLS_PROGRAM && st.op == ST_ER_SUSP
         && cmd_sector_i == st.sector && rst_lvl |=> st.refuse && st.op == ST_ER_SUSP)
      else $error("program to suspended sector accepted");

   erase_standby_only_a: assert property ( // RULE9
      cmd_valid_i && (cmd_class_i == CLS_SECT_ERASE || cmd_class_i == CLS_SUBSECT_ERASE)
         && st.op != ST_STANDBY && rst_lvl |=> st.refuse)
      else $error("erase accepted outside standby");

   prot_standby_only_a: assert property ( // RULE10
      cmd_valid_i && cmd_class_i == CLS_PROT_WRITE && st.op != ST_STANDBY && rst_lvl
         |=> st.refuse && !st.acc)
      else $error("protected write accepted outside standby");

   light_busy_refused_a: assert property ( // RULE11
      cmd_valid_i && cmd_class_i == CLS_LIGHT_WRITE && st.op == ST_BUSY && rst_lvl
         |=> st.refuse && !st.acc)
      else $error("light write accepted while busy");

   refused_stable_a: assert property ( // RULE24
      cmd_valid_i && !cmd_ok && !op_done_i && !first_dummy_i && !rescue_done && rst_lvl
         |=> $stable(st.op) && $stable(st.vcr3)
         && $stable(st.xip) && $stable(st.sector))
      else $error("refused command changed state");

   suspend_moves_a: assert property ( // RULE25
      cmd_valid_i && cmd_class_i == CLS_SUSPEND && st.op == ST_BUSY && !op_done_i && rst_lvl
         |=> st.op == ST_PS_SUSP || st.op == ST_ER_SUSP)
      else $error("accepted suspend did not suspend");

   confirm_exit_a: assert property ( // RULE15
      first_dummy_i && st.xip && io0_lvl && !st.boot && rst_lvl
         |=> !st.xip && st.vcr3)
      else $error("confirmation one did not leave the mode");

   boot_into_mode_a: assert property ( // RULE17
      st.boot && rst_lvl && nvcr_xip_sel_i != `NVCR_XIP_OFF
         |=> st.xip)
      else $error("did not boot into address-only read mode");

   enter_mode_c: cover property (!st.xip ##1 st.xip && !$past(st.boot));
   suspend_c: cover property (st.op == ST_BUSY ##1 st.op == ST_ER_SUSP);
   resume_c: cover property (st.op == ST_PS_SUSP ##1 st.op == ST_BUSY);
   same_sector_c: cover property (st.unsure);

endmodule : op_admission_and_xip_ctrl

`default_nettype wire

// File: sim/flash_host_model.sv
`timescale 1ns/1ns
`default_nettype none

// Host controller model; chip select and clock move only inside its tasks, line zero also toggles while deselected
module flash_host_model (
   output logic cs_n_o, // Chip select, low selects the device
   output logic sclk_o, // Link clock, still outside frames
   output logic io_line_zero_o // Data line zero
);
   localparam int HALF = 400; // Half of the 800 ns link period

   // Idle levels at time zero
   initial begin
      cs_n_o = 1'b1;
      sclk_o = 1'b0;
      io_line_zero_o = 1'b0;
   end

   // Deselected line zero toggles, so a stale level never looks driven
   always #HALF begin
      if (cs_n_o) begin
         io_line_zero_o = ~io_line_zero_o;
      end
   end

   // Select and hold the confirmation level on line zero; address-only frames need no opcode
   task automatic select(input logic v);
      cs_n_o = 1'b0;
      io_line_zero_o = v;
   endtask : select

   // End the frame; chip select high deselects
   task automatic deselect();
      #HALF;
      cs_n_o = 1'b1;
      #HALF;
   endtask : deselect

   // One chip-select-low burst of n clocks, closed before a further clock
   task automatic burst(input int n);
      cs_n_o = 1'b0;
      #HALF;
      repeat (n) begin
         sclk_o = 1'b1;
         #HALF;
         sclk_o = 1'b0;
         #HALF;
      end
      cs_n_o = 1'b1;
      #(4 * HALF);
   endtask : burst

   // Six bursts in the fixed order that ends address-only reads
   task automatic rescue();
      int lens [6] = '{7, 9, 13, 17, 25, 33};
      for (int i = 0; i < 6; i++) begin
         burst(lens[i]);
      end
   endtask : rescue

   // Reset-enable then reset-memory, one byte frame each
   task automatic soft_reset();
      burst(8);
      burst(8);
   endtask : soft_reset
endmodule : flash_host_model

`default_nettype wire

// File: sim/tb.sv
`timescale 1ns/1ns
`default_nettype none

module tb
   import op_admission_pkg::*;
;
   logic ref_clk_i, nrst_i, cs_n, sclk, line_zero, rst_pin_n, quad_mode, basic_var;
   logic [2:0] nvcr_sel; // Nonvolatile boot field
   logic cmd_valid, vcr_wr, vcr_bit, first_dummy, op_done;
   cmd_class_type cmd_class; // Decoded class under test
   logic [10:0] cmd_sector;
   logic [1:0] op_state;
   logic acc, refuse, unsure, xip, vcr_o, sel;
   int error_cnt = 0; // Mismatches seen
   int n_tests = 0; // Comparisons made

   op_admission_and_xip_ctrl dut_u (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .cs_n_i(cs_n),
      .sclk_i(sclk), .io_line_zero_i(line_zero), .rst_pin_n_i(rst_pin_n), .quad_mode_i(quad_mode),
      .basic_variant_i(basic_var), .nvcr_xip_sel_i(nvcr_sel), .cmd_valid_i(cmd_valid),
      .cmd_class_i(cmd_class), .cmd_sector_i(cmd_sector), .vcr_wr_i(vcr_wr),
      .vcr_xip_bit_i(vcr_bit), .first_dummy_i(first_dummy), .op_done_i(op_done),
      .op_state_o(op_state), .cmd_accept_o(acc), .cmd_refuse_o(refuse),
      .read_unsure_o(unsure), .xip_active_o(xip), .vcr_xip_bit_o(vcr_o), .selected_o(sel));

   flash_host_model host_u (.cs_n_o(cs_n), .sclk_o(sclk), .io_line_zero_o(line_zero));

   // 10 MHz block clock
   initial begin
      ref_clk_i = 1'b0;
      forever #50 ref_clk_i = ~ref_clk_i;
   end

   task automatic results();
      $display("tests %0d errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : results

   task automatic chk_bit(input string what, input logic exp, input logic got);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %b seen %b", what, exp, got);
      end
   endtask : chk_bit

   task automatic chk_state(input logic [1:0] exp);
      n_tests++;
      if (op_state !== exp) begin
         error_cnt++;
         $display("mismatch op_state expected %0d seen %0d", exp, op_state);
      end
   endtask : chk_state

   // Admission table, state by class; hit means the erase-suspended sector
   function automatic logic admit(input logic [1:0] st, input cmd_class_type c, input logic hit);
      case (c)
         CLS_ARRAY_READ: return st != 2'h1;
         CLS_STATUS_READ: return 1'b1;
         CLS_PROGRAM: return st == 2'h0 || (st == 2'h3 && !hit);
         CLS_SECT_ERASE, CLS_SUBSECT_ERASE, CLS_PROT_WRITE: return st == 2'h0;
         CLS_LIGHT_WRITE: return st != 2'h1;
         CLS_SUSPEND: return st == 2'h1;
         default: return st[1];
      endcase
   endfunction : admit

   // One-cycle command, answer judged the cycle after it is taken
   task automatic cmd(input cmd_class_type c, input logic [10:0] s, input logic hit,
                      input logic [1:0] st, input logic [1:0] st_after);
      logic e;
      e = admit(st, c, hit);
      @(posedge ref_clk_i);
      cmd_valid <= 1'b1;
      cmd_class <= c;
      cmd_sector <= s;
      @(posedge ref_clk_i);
      cmd_valid <= 1'b0;
      @(negedge ref_clk_i);
      chk_bit("accept", e, acc);
      chk_bit("refuse", !e, refuse);
      chk_bit("unsure", e && hit && c == CLS_ARRAY_READ, unsure);
      chk_state(st_after);
   endtask : cmd

   // Every class that leaves the state alone; refused ones must change nothing
   task automatic sweep(input logic [1:0] st, input logic [10:0] s, input logic hit);
      cmd_class_type c;
      for (int i = 0; i < 9; i++) begin
         c = cmd_class_type'(i);
         if (!(admit(st, c, hit) && !(c inside {CLS_ARRAY_READ, CLS_STATUS_READ,
               CLS_LIGHT_WRITE}))) begin
            cmd(c, s, hit, st, st);
         end
      end
   endtask : sweep

   task automatic done_op(input logic [1:0] st);
      @(posedge ref_clk_i);
      op_done <= 1'b1;
      @(posedge ref_clk_i);
      op_done <= 1'b0;
      @(negedge ref_clk_i);
      chk_state(st);
   endtask : done_op

   task automatic do_reset();
      @(posedge ref_clk_i);
      nrst_i <= 1'b0;
      repeat (20) @(posedge ref_clk_i);
      nrst_i <= 1'b1;
      repeat (6) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
   endtask : do_reset

   // Fast read whose first dummy clock carries confirmation level v
   task automatic confirm(input logic v, input logic exp_xip);
      host_u.select(v);
      repeat (8) @(posedge ref_clk_i);
      first_dummy <= 1'b1;
      @(posedge ref_clk_i);
      first_dummy <= 1'b0;
      @(negedge ref_clk_i);
      chk_bit("xip", exp_xip, xip);
      chk_bit("selected", 1'b1, sel);
      host_u.deselect();
      repeat (6) @(posedge ref_clk_i);
      chk_bit("deselected", 1'b0, sel);
   endtask : confirm

   task automatic vcr_write(input logic b);
      vcr_wr <= 1'b1;
      vcr_bit <= b;
      cmd(CLS_LIGHT_WRITE, 11'h000, 1'b0, 2'h0, 2'h0);
      vcr_wr <= 1'b0;
      chk_bit("vcr", b, vcr_o);
   endtask : vcr_write

   task automatic t_states();
      sweep(2'h0, 11'h005, 1'b0);
      cmd(CLS_PROGRAM, 11'h005, 1'b0, 2'h0, 2'h1);
      sweep(2'h1, 11'h3FF, 1'b0);
      cmd(CLS_SUSPEND, 11'h005, 1'b0, 2'h1, 2'h2);
      sweep(2'h2, 11'h006, 1'b0);
      cmd(CLS_RESUME, 11'h005, 1'b0, 2'h2, 2'h1);
      done_op(2'h0);
      cmd(CLS_SUBSECT_ERASE, 11'h009, 1'b0, 2'h0, 2'h1);
      cmd(CLS_SUSPEND, 11'h009, 1'b0, 2'h1, 2'h2);
      cmd(CLS_RESUME, 11'h009, 1'b0, 2'h2, 2'h1);
      done_op(2'h0);
      cmd(CLS_PROT_WRITE, 11'h000, 1'b0, 2'h0, 2'h1);
      done_op(2'h0);
   endtask : t_states

   task automatic t_erase_susp();
      cmd(CLS_SECT_ERASE, 11'h020, 1'b0, 2'h0, 2'h1);
      cmd(CLS_SUSPEND, 11'h020, 1'b0, 2'h1, 2'h3);
      sweep(2'h3, 11'h020, 1'b1);
      cmd(CLS_PROGRAM, 11'h7FF, 1'b0, 2'h3, 2'h1);
      done_op(2'h3);
      cmd(CLS_RESUME, 11'h020, 1'b0, 2'h3, 2'h1);
      done_op(2'h0);
   endtask : t_erase_susp

   task automatic t_xip();
      confirm(1'b0, 1'b0);
      vcr_write(1'b0);
      confirm(1'b0, 1'b1);
      confirm(1'b1, 1'b0);
      chk_bit("vcr", 1'b1, vcr_o);
      basic_var <= 1'b1;
      confirm(1'b0, 1'b1);
      confirm(1'b1, 1'b0);
      basic_var <= 1'b0;
   endtask : t_xip

   task automatic t_rescue();
      vcr_write(1'b0);
      confirm(1'b0, 1'b1);
      cmd(CLS_PROGRAM, 11'h001, 1'b0, 2'h0, 2'h1);
      host_u.rescue();
      repeat (10) @(posedge ref_clk_i);
      chk_bit("xip", 1'b0, xip);
      chk_state(2'h1);
      host_u.soft_reset();
      done_op(2'h0);
   endtask : t_rescue

   task automatic t_reset_pin();
      vcr_write(1'b0);
      confirm(1'b0, 1'b1);
      cmd(CLS_PROGRAM, 11'h001, 1'b0, 2'h0, 2'h1);
      quad_mode <= 1'b1;
      host_u.select(1'b1);
      rst_pin_n <= 1'b0;
      repeat (10) @(posedge ref_clk_i);
      chk_bit("xip", 1'b1, xip);
      chk_state(2'h1);
      host_u.deselect();
      repeat (8) @(posedge ref_clk_i);
      chk_bit("xip", 1'b0, xip);
      chk_state(2'h0);
      chk_bit("vcr", 1'b1, vcr_o);
      rst_pin_n <= 1'b1;
      quad_mode <= 1'b0;
      repeat (6) @(posedge ref_clk_i);
   endtask : t_reset_pin

   task automatic t_boot();
      nvcr_sel <= 3'h2;
      do_reset();
      chk_bit("xip", 1'b1, xip);
      confirm(1'b1, 1'b0);
      @(posedge ref_clk_i);
      rst_pin_n <= 1'b0;
      repeat (8) @(posedge ref_clk_i);
      rst_pin_n <= 1'b1;
      repeat (8) @(posedge ref_clk_i);
      chk_bit("xip", 1'b1, xip);
   endtask : t_boot

   // Watchdog; the whole run needs under two thousand cycles
   initial begin
      repeat (40000) @(posedge ref_clk_i);
      error_cnt++;
      $display("mismatch watchdog expected finish seen timeout");
      results();
   end

   // Main sequence
   initial begin
      nrst_i = 1'b0;
      rst_pin_n = 1'b1;
      quad_mode = 1'b0;
      basic_var = 1'b0;
      nvcr_sel = 3'h7;
      cmd_valid = 1'b0;
      cmd_class = CLS_ARRAY_READ;
      cmd_sector = 11'h000;
      vcr_wr = 1'b0;
      vcr_bit = 1'b1;
      first_dummy = 1'b0;
      op_done = 1'b0;
      do_reset();
      chk_state(2'h0);
      chk_bit("xip", 1'b0, xip);
      chk_bit("vcr", 1'b1, vcr_o);
      t_states();
      t_erase_susp();
      t_xip();
      t_rescue();
      t_reset_pin();
      t_boot();
      results();
   end
endmodule : tb

`default_nettype wire
